// File: shared/sac_pkg.sv
// Shared constants and types for the serial converter control port.
package sac_pkg;
    // System clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 25;
    // Default result width in bits; twelve is the other legal value.
    localparam int RES_BITS_DEF = 14;
    // Width of the digitised analog input samples.
    localparam int AIN_W = 17;
    // Input samples are in steps of one reference span divided by 2**SPAN_FRAC.
    localparam int SPAN_FRAC = 16;
    // Positive full-scale limit in input steps, half the reference span.
    localparam int FULL_SCALE_UNITS = 32768;
    // Serial clock edge counts after an accepted convert-start.
    localparam logic [4:0] FIRST_BIT_EDGE = 5'h03;
    localparam logic [4:0] LOCKOUT_EDGES = 5'h10;
    localparam logic [4:0] FRAME_EDGES = 5'h11;
    // Convert-start edges without serial clock edges that enter nap and sleep.
    localparam logic [2:0] NAP_EDGES = 3'h2;
    localparam logic [2:0] SLEEP_EDGES = 3'h4;
    // Depth of the result buffer.
    localparam int FIFO_DEPTH = 8;
    // Reference settling time after sleep, in milliseconds, and in clock cycles.
    localparam int REF_SETTLE_MS = 2;
    localparam int REF_SETTLE_CYC = (REF_SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        SAC_ACTIVE = 2'b00,
        SAC_NAP = 2'b01,
        SAC_SLEEP = 2'b10
    } sac_pwr_e;
endpackage

// File: src/sac_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/100ps
module sac_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("sac_fifo depth must be a power of two, at least two");
    end

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } sac_fifo_s;

    sac_fifo_s st_r;
    sac_fifo_s st_nxt;
    logic push;
    logic pop;

    assign in_ready_out = (st_r.cnt != FULL_CNT);
    assign out_valid_out = (st_r.cnt != '0);
    assign out_data_out = st_r.mem[st_r.rd];

    always_comb
    begin
        st_nxt = st_r;
        push = in_valid_in && (st_r.cnt != FULL_CNT);
        pop = out_ready_in && (st_r.cnt != '0);
        if (push)
        begin
            st_nxt.mem[st_r.wr] = in_data_in;
            st_nxt.wr = st_r.wr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rd = st_r.rd + 1'b1;
        end
        if (push && !pop)
        begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// File: src/sac_adc_port.sv
// Conversion control, serial result port and power-down keying of the converter.
`timescale 1ns/100ps
//
// Overview of operation
// - Input difference above positive full scale gives zero sign bit then all ones.
// - Input difference below negative full scale gives one sign bit then all zeros.
// - Results are two's complement; one step is reference span over 2**bits.
// - After power-up the port is active and accepts a conversion at once.
// - Two convert-start edges with no serial clock edge between enter nap.
// - The reference stays powered during nap.
// - A serial clock edge wakes from nap; a conversion may follow once the one still running ends its lockout.
// - Four convert-start edges with no serial clock edge between enter sleep.
// - Convert-start samples and starts; further starts ignored for sixteen clock edges.
// - The whole result leaves within the first sixteen clock periods.
// - Only the rising edge of convert-start matters, any duty cycle works.
// - Three wires: clock and convert-start in, serial data out.
// - From the third clock edge after start, bits leave MSB first, one per edge.
// - Serial data is high impedance whenever no result bit is being driven.
// - Each word carries the sample taken at the previous conversion start.
module sac_adc_port #(
    parameter int RES_BITS = sac_pkg::RES_BITS_DEF,
    parameter int REF_SETTLE_CYCLES = sac_pkg::REF_SETTLE_CYC
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic sck_in,
    input wire logic convert_start_in,
    input wire logic [sac_pkg::AIN_W-1:0] positive_analog_input_in,
    input wire logic [sac_pkg::AIN_W-1:0] negative_analog_input_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic nap_out,
    output logic sleep_out,
    output logic reference_on_out,
    output logic reference_settled_out,
    output logic converting_out
);
    localparam int AW = sac_pkg::AIN_W;
    localparam int DW = AW + 2;
    localparam int SHIFT = sac_pkg::SPAN_FRAC - RES_BITS;
    localparam int SETTLE_W = $clog2(REF_SETTLE_CYCLES + 1);
    localparam logic signed [DW-1:0] HALF_STEP = DW'(1 << (SHIFT - 1));
    localparam logic signed [DW-1:0] FS_POS = DW'(sac_pkg::FULL_SCALE_UNITS);
    localparam logic signed [DW-1:0] FS_NEG = -FS_POS;
    localparam logic signed [DW-1:0] CODE_MAX = DW'((1 << (RES_BITS - 1)) - 1);
    localparam logic signed [DW-1:0] CODE_MIN = -DW'(1 << (RES_BITS - 1));
    localparam logic [4:0] LAST_BIT_EDGE = 5'(2 + RES_BITS);
    localparam logic [4:0] RELEASE_EDGE = 5'(3 + RES_BITS);
    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(REF_SETTLE_CYCLES - 1);

    if (RES_BITS != 12 && RES_BITS != 14)
    begin : g_bad_res
        $error("sac_adc_port result width must be 12 or 14");
    end
    if (REF_SETTLE_CYCLES < 1)
    begin : g_bad_settle
        $error("sac_adc_port settle count must be at least one");
    end

    typedef struct packed
    {
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic cv_s1;
        logic cv_s2;
        logic cv_d;
        logic [AW-1:0] pos_s1;
        logic [AW-1:0] pos_s2;
        logic [AW-1:0] neg_s1;
        logic [AW-1:0] neg_s2;
        sac_pkg::sac_pwr_e pwr;
        logic [2:0] quiet;
        logic busy;
        logic [4:0] edges;
        logic [RES_BITS-1:0] code;
        logic push_pend;
        logic [RES_BITS-1:0] shreg;
        logic sdo;
        logic sdo_oe;
        logic [SETTLE_W-1:0] settle_cnt;
        logic settled;
    } sac_port_s;

    sac_port_s st_r;
    sac_port_s st_nxt;

    logic sck_rise;
    logic cv_rise;
    logic start;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RES_BITS-1:0] fifo_out_data;
    logic [RES_BITS-1:0] sample_code;

    // Quantise the held input difference into a saturating two's complement code.
    function automatic logic [RES_BITS-1:0] to_code(input logic [AW-1:0] pos,
                                                    input logic [AW-1:0] neg);
        logic signed [DW-1:0] diff;
        logic signed [DW-1:0] rounded;
        logic [RES_BITS-1:0] code;
        diff = $signed({2'b00, pos}) - $signed({2'b00, neg});
        rounded = (diff + HALF_STEP) >>> SHIFT;
        code = rounded[RES_BITS-1:0];
        if (diff > FS_POS || rounded > CODE_MAX)
        begin
            code = {1'b0, {(RES_BITS - 1){1'b1}}};
        end
        else if (diff < FS_NEG || rounded < CODE_MIN)
        begin
            code = {1'b1, {(RES_BITS - 1){1'b0}}};
        end
        return code;
    endfunction

    assign sdo_out = st_r.sdo;
    assign sdo_oe_out = st_r.sdo_oe;
    assign nap_out = (st_r.pwr == sac_pkg::SAC_NAP);
    assign sleep_out = (st_r.pwr == sac_pkg::SAC_SLEEP);
    assign reference_on_out = (st_r.pwr != sac_pkg::SAC_SLEEP);
    assign reference_settled_out = st_r.settled;
    assign converting_out = st_r.busy;

    // Edges are found on the second synchroniser stage against its delayed copy.
    assign sck_rise = st_r.sck_s2 && !st_r.sck_d;
    assign cv_rise = st_r.cv_s2 && !st_r.cv_d;
    assign start = cv_rise && !st_r.busy && (st_r.pwr == sac_pkg::SAC_ACTIVE);
    assign sample_code = to_code(st_r.pos_s2, st_r.neg_s2);

    // Results wait here for one conversion before they are shifted out.
    sac_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(sac_pkg::FIFO_DEPTH)
    ) u_result_fifo (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .in_valid_in(st_r.push_pend),
        .in_ready_out(fifo_in_ready),
        .in_data_in(st_r.code),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(start),
        .out_data_out(fifo_out_data)
    );

    always_comb
    begin
        st_nxt = st_r;

        st_nxt.sck_s1 = sck_in;
        st_nxt.sck_s2 = st_r.sck_s1;
        st_nxt.sck_d = st_r.sck_s2;
        st_nxt.cv_s1 = convert_start_in;
        st_nxt.cv_s2 = st_r.cv_s1;
        st_nxt.cv_d = st_r.cv_s2;
        st_nxt.pos_s1 = positive_analog_input_in;
        st_nxt.pos_s2 = st_r.pos_s1;
        st_nxt.neg_s1 = negative_analog_input_in;
        st_nxt.neg_s2 = st_r.neg_s1;

        // Finished results move into the buffer; a full buffer holds them here.
        if (st_r.push_pend && fifo_in_ready)
        begin
            st_nxt.push_pend = 1'b0;
        end

        // Count convert-start edges that arrive with no clock edge in between.
        if (sck_rise)
        begin
            st_nxt.quiet = cv_rise ? 3'h1 : 3'h0;
        end
        else if (cv_rise && st_r.quiet != sac_pkg::SLEEP_EDGES)
        begin
            st_nxt.quiet = st_r.quiet + 3'h1;
        end

        unique case (st_r.pwr)
            sac_pkg::SAC_ACTIVE:
            begin
                if (!sck_rise && st_nxt.quiet == sac_pkg::SLEEP_EDGES)
                begin
                    st_nxt.pwr = sac_pkg::SAC_SLEEP;
                    st_nxt.settled = 1'b0;
                end
                else if (!sck_rise && st_nxt.quiet == sac_pkg::NAP_EDGES)
                begin
                    st_nxt.pwr = sac_pkg::SAC_NAP;
                end
            end
            sac_pkg::SAC_NAP:
            begin
                if (sck_rise)
                begin
                    st_nxt.pwr = sac_pkg::SAC_ACTIVE;
                end
                else if (st_nxt.quiet == sac_pkg::SLEEP_EDGES)
                begin
                    st_nxt.pwr = sac_pkg::SAC_SLEEP;
                    st_nxt.settled = 1'b0;
                end
            end
            sac_pkg::SAC_SLEEP:
            begin
                if (sck_rise)
                begin
                    st_nxt.pwr = sac_pkg::SAC_ACTIVE;
                    st_nxt.settle_cnt = SETTLE_LOAD;
                end
            end
            default:
            begin
                st_nxt.pwr = sac_pkg::SAC_ACTIVE;
            end
        endcase

        // The reference counts its settling time once awake again.
        if (st_r.pwr != sac_pkg::SAC_SLEEP && !st_r.settled)
        begin
            if (st_r.settle_cnt == '0)
            begin
                st_nxt.settled = 1'b1;
            end
            else
            begin
                st_nxt.settle_cnt = st_r.settle_cnt - 1'b1;
            end
        end

        if (start)
        begin
            // Hold the inputs and hand out the previous conversion's result.
            st_nxt.busy = 1'b1;
            st_nxt.edges = '0;
            st_nxt.code = sample_code;
            st_nxt.shreg = fifo_out_valid ? fifo_out_data : '0;
            st_nxt.sdo = 1'b0;
            st_nxt.sdo_oe = 1'b0;
        end
        else if (sck_rise && st_r.edges != sac_pkg::FRAME_EDGES)
        begin
            st_nxt.edges = st_r.edges + 5'h01;
            if (st_nxt.edges >= sac_pkg::FIRST_BIT_EDGE && st_nxt.edges <= LAST_BIT_EDGE)
            begin
                st_nxt.sdo = st_r.shreg[RES_BITS-1];
                st_nxt.sdo_oe = 1'b1;
                st_nxt.shreg = {st_r.shreg[RES_BITS-2:0], 1'b0};
            end
            else if (st_nxt.edges == RELEASE_EDGE)
            begin
                st_nxt.sdo = 1'b0;
                st_nxt.sdo_oe = 1'b0;
            end
            if (st_nxt.edges == sac_pkg::LOCKOUT_EDGES)
            begin
                st_nxt.busy = 1'b0;
                st_nxt.push_pend = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_r <= '0;
            st_r.pwr <= sac_pkg::SAC_ACTIVE;
            st_r.edges <= sac_pkg::FRAME_EDGES;
            st_r.settled <= 1'b1;
            st_r.sdo_oe <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// File: sim/sac_adc_port_asserts.sv
// Concurrent checks on the converter control port.
`timescale 1ns/100ps
module sac_adc_port_asserts #(
    parameter int RES_BITS = 14
) (
    input logic clock_in,
    input logic resetn_in,
    input logic sck_in,
    input logic convert_start_in,
    input logic sdo_out,
    input logic sdo_oe_out,
    input logic nap_out,
    input logic sleep_out,
    input logic reference_on_out,
    input logic converting_out
);
    logic [2:0] sck_q;
    logic [2:0] cs_q;
    logic [4:0] convert_start_edges;
    logic [4:0] oe_edges;
    logic [2:0] quiet_cs;
    wire sck_rise = sck_q[1] & ~sck_q[2];
    wire cs_rise = cs_q[1] & ~cs_q[2];

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    // Edges are found after the same two-flop delay that the port uses.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sck_q <= '0;
            cs_q <= '0;
            convert_start_edges <= '0;
            oe_edges <= '0;
            quiet_cs <= '0;
        end
        else
        begin
            sck_q <= {sck_q[1:0], sck_in};
            cs_q <= {cs_q[1:0], convert_start_in};
            convert_start_edges <= converting_out ? convert_start_edges + 5'(sck_rise) : 5'h00;
            oe_edges <= sdo_oe_out ? oe_edges + 5'(sck_rise) : 5'h00;
            quiet_cs <= sck_rise ? 3'h0 : quiet_cs + 3'(cs_rise);
        end
    end

    chk_ref_in_nap: assert property (nap_out |-> reference_on_out)
        else $error("reference off during nap");
    chk_sleep_ref_off: assert property (sleep_out |-> !reference_on_out)
        else $error("reference on during sleep");
    chk_idle_low: assert property (!sdo_oe_out |-> !sdo_out)
        else $error("serial data driven while released");
    chk_bits_per_word: assert property ($fell(sdo_oe_out) |-> oe_edges == 5'(RES_BITS))
        else $error("wrong number of bits in a word");
    chk_lockout_len: assert property ($fell(converting_out) |-> convert_start_edges == 5'h10)
        else $error("lockout not sixteen clock edges");
    chk_first_bit: assert property ($rose(sdo_oe_out) |-> convert_start_edges == 5'h03)
        else $error("first bit not on third clock edge");
    chk_wake_nap: assert property (nap_out && sck_rise |-> ##[1:2] !nap_out)
        else $error("clock edge did not wake from nap");
    chk_nap_entry: assert property (cs_rise && quiet_cs == 3'h1 |-> ##[1:2] nap_out)
        else $error("two starts did not enter nap");
endmodule

bind sac_adc_port sac_adc_port_asserts #(.RES_BITS(RES_BITS)) u_asserts (
    .clock_in(clock_in), .resetn_in(resetn_in), .sck_in(sck_in),
    .convert_start_in(convert_start_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
    .nap_out(nap_out), .sleep_out(sleep_out), .reference_on_out(reference_on_out),
    .converting_out(converting_out));

// File: sim/sac_host_model.sv
// Host serial port model driving clock and convert-start and gathering words.
`timescale 1ns/100ps
module sac_host_model #(
    parameter int RES_BITS = 14
) (
    output logic sck_out,
    output logic convert_start_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_in,
    output logic [RES_BITS-1:0] word_out,
    output logic word_valid_out
);
    initial
    begin
        sck_out = 1'b0;
        convert_start_out = 1'b0;
        word_out = '0;
        word_valid_out = 1'b0;
    end

    // The clock stands low between bursts; each bit is taken on the falling clock edge.
    task automatic clocks(input int n, input int mode);
        #7;
        for (int k = 1; k <= n; k++)
        begin
            #100 sck_out = 1'b1;
            #100 sck_out = 1'b0;
            if (k >= 3 && k <= RES_BITS + 2)
                word_out[RES_BITS + 2 - k] = sdo_oe_in ? sdo_in : 1'bx;
            convert_start_out = (mode == 1 && k < 10) || (mode == 2 && k == 8);
        end
    endtask

    // Mode 1 holds convert-start high long, mode 2 adds a start inside the lockout.
    task automatic frame(input int mode);
        #7 convert_start_out = 1'b1;
        clocks(17, mode);
        #200 word_valid_out = 1'b1;
        #10 word_valid_out = 1'b0;
    endtask

    task automatic pulses(input int n);
        repeat (n)
        begin
            #7 convert_start_out = 1'b1;
            #200 convert_start_out = 1'b0;
            #200;
        end
    endtask
endmodule

// File: sim/sac_adc_port_tb_top.sv
// Self-checking bench for the converter control port.
`timescale 1ns/100ps
module sac_adc_port_tb_top;
    localparam int RB = 14;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [16:0] pos = '0;
    logic [16:0] neg = '0;
    logic sck, cs, sdo, oe, nap, slp, ref_on, ref_ok, busy, wv;
    logic [RB-1:0] word;
    logic [RB-1:0] prev = '0;
    logic [RB-1:0] exp_q[$];
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    always #12.5 clock_in = ~clock_in;

    sac_adc_port #(.RES_BITS(RB), .REF_SETTLE_CYCLES(20)) DUT (
        .clock_in(clock_in), .resetn_in(resetn_in), .sck_in(sck), .convert_start_in(cs),
        .positive_analog_input_in(pos), .negative_analog_input_in(neg), .sdo_out(sdo),
        .sdo_oe_out(oe), .nap_out(nap), .sleep_out(slp), .reference_on_out(ref_on),
        .reference_settled_out(ref_ok), .converting_out(busy));
    sac_host_model #(.RES_BITS(RB)) host (.sck_out(sck), .convert_start_out(cs), .sdo_in(sdo),
        .sdo_oe_in(oe), .word_out(word), .word_valid_out(wv));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic logic [RB-1:0] code_of(input logic [16:0] p, input logic [16:0] n);
        int d;
        d = int'(p) - int'(n);
        if (d > 32767) return 14'h1fff;
        if (d < -32768) return 14'h2000;
        return RB'(d >>> 2);
    endfunction

    // A word carries the code sampled one conversion earlier.
    task automatic convert_start_frame(input logic [16:0] p, input logic [16:0] n, input int mode);
        @(posedge clock_in);
        pos <= p;
        neg <= n;
        @(posedge clock_in);
        exp_q.push_back(prev);
        prev = code_of(p, n);
        host.frame(mode);
    endtask

    always @(posedge wv)
        check(16'(word), 16'(exp_q.pop_front()));

    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    initial
    begin
        int k;
        logic [16:0] nr;
        k = $urandom(32'h308dee03);
        repeat (6) @(posedge clock_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        check(16'(oe), 16'h0);
        check(16'({nap, slp, ref_on, ref_ok}), 16'h3);
        convert_start_frame(17'h1ffff, 17'h00000, 0);
        convert_start_frame(17'h00000, 17'h1ffff, 1);
        convert_start_frame(17'h17ffc, 17'h10000, 2);
        convert_start_frame(17'h08000, 17'h10000, 0);
        for (int i = 0; i < 8; i++)
        begin
            nr = 17'h08000 + 17'($urandom_range(32767));
            k = $urandom_range(16383) - 8192;
            convert_start_frame(17'(int'(nr) + 4 * k), nr, i % 3);
        end
        host.pulses(2);
        repeat (4) @(posedge clock_in);
        check(16'({nap, slp, ref_on}), 16'h5);
        host.clocks(17, 0);
        check(16'(nap), 16'h0);
        check(16'(busy), 16'h0);
        convert_start_frame(17'h12340, 17'h10000, 0);
        host.pulses(4);
        repeat (4) @(posedge clock_in);
        check(16'({slp, ref_on, ref_ok}), 16'h4);
        check(16'(busy), 16'h1);
        host.clocks(1, 0);
        repeat (2) @(posedge clock_in);
        check(16'(ref_ok), 16'h0);
        host.clocks(16, 0);
        check(16'({slp, ref_on, ref_ok}), 16'h3);
        convert_start_frame(17'h0fff0, 17'h10000, 0);
        convert_start_frame(17'h10000, 17'h10000, 0);
        stop_test();
    end
endmodule
